// ### shared/pixel_sync_pkg.sv
`default_nettype none
package pixel_sync_pkg;
	// multiplexing ratios between pixel clock and load strobe
	localparam logic [2:0] MUX_RATIO_4 = 3'h4;
	localparam logic [2:0] MUX_RATIO_5 = 3'h5;
	// pipeline latency in pixel clock cycles
	localparam logic [3:0] LATENCY_MIN = 4'h6;
	localparam logic [3:0] LATENCY_MAX = 4'ha;
	localparam logic [3:0] LATENCY_ALIGNED = 4'h8;
	localparam int LATENCY_DEPTH = 10;
	// load strobe rising edges needed while the clock pair is frozen
	localparam logic [1:0] FREEZE_EDGES = 2'h3;
	// reset values and blink counter width
	localparam logic [2:0] PHASE_RESET = 3'h0;
	localparam logic [1:0] FREEZE_COUNT_RESET = 2'h0;
	localparam int BLINK_WIDTH = 16;
endpackage
`default_nettype wire

// ### test/clk_gen_model.sv
`default_nettype none
module clk_gen_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic mux_5to1,
	input wire logic freeze,
	output logic pixel_clk_true,
	output logic pixel_clk_comp,
	output logic load_strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic hold;
	logic [3:0] ratio;
	assign ratio = mux_5to1 ? 4'h5 : 4'h4;
	assign load_strobe = cnt < ratio;
	assign pixel_clk_comp = !pixel_clk_true;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 4'h0;
			hold <= 1'b0;
			pixel_clk_true <= 1'b0;
		end else begin
			cnt <= (cnt == 2 * ratio - 1) ? 4'h0 : cnt + 4'h1;
			// restart one ref cycle after a load rise
			if (freeze && pixel_clk_true) hold <= 1'b1;
			else if (!freeze && cnt == 2 * ratio - 1) hold <= 1'b0;
			pixel_clk_true <= (hold || (freeze && pixel_clk_true)) ? 1'b1 : !pixel_clk_true;
		end
	end
endmodule
`default_nettype wire

// ### test/pixel_load_pipeline_sync_tb.sv
`default_nettype none
module pixel_load_pipeline_sync_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, mux_5to1 = 0, freeze = 0, pct, pcc, ld, fixed;
	logic [7:0] pixel_in = 8'h00, pixel_out;
	logic [3:0] lat;
	logic [1:0] fcnt;
	logic [2:0] ph;
	logic [15:0] blink, b0;
	int err_count = 0, samples_checked = 0, cyc = 0, n;
	always #5 ref_clk = ~ref_clk;
	clk_gen_model clk_gen_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .mux_5to1(mux_5to1),
		.freeze(freeze), .pixel_clk_true(pct), .pixel_clk_comp(pcc), .load_strobe(ld));
	pixel_load_pipeline_sync pixel_load_pipeline_sync_i (.ref_clk(ref_clk), .rst_n(rst_n),
		.pixel_clk_true(pct), .pixel_clk_comp(pcc), .load_strobe(ld), .mux_5to1(mux_5to1),
		.pixel_in(pixel_in), .pixel_out(pixel_out), .serial_phase(ph), .latency_cycles(lat),
		.latency_fixed(fixed), .freeze_count(fcnt), .blink_count(blink));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// pulse one pixel and count ref cycles until it leaves
	task automatic meas(input int exp);
		while (pct !== 1'b0) @(posedge ref_clk) #1;
		// the rise is seen one edge after the pin goes high, so hold for two edges
		pixel_in = 8'h5a;
		@(posedge ref_clk) #1;
		@(posedge ref_clk) #1;
		pixel_in = 8'h00;
		n = 0;
		while (pixel_out !== 8'h5a && n < 40) begin
			@(posedge ref_clk) #1;
			n++;
		end
		check(16'(n), 16'(exp));
	endtask
	task automatic align();
		freeze = 1;
		repeat (80) @(posedge ref_clk) #1;
		check({14'h0, fcnt}, 16'h3);
		b0 = blink;
		freeze = 0;
		n = 0;
		// wait for the restart fall itself, which clears the freeze count
		while ((fixed !== 1'b1 || fcnt !== 2'h0) && n < 30) begin
			@(posedge ref_clk) #1;
			n++;
		end
		check({12'h0, lat}, 16'h8);
		check({13'h0, ph}, 16'h0);
		check({15'h0, blink >= b0}, 16'h1);
	endtask
	always @(posedge ref_clk) if (++cyc == 3000) begin
		err_count++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rst_n = 1;
		meas(12);
		check({15'h0, fixed}, 16'h0);
		align();
		meas(16);
		mux_5to1 = 1;
		align();
		meas(16);
		summarize();
	end
endmodule
`default_nettype wire

// ### test/sync_checker_sva.sv
`default_nettype none
module sync_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pixel_clk_true,
	input wire logic load_strobe,
	input wire logic [3:0] latency_cycles,
	input wire logic latency_fixed,
	input wire logic [2:0] serial_phase,
	input wire logic [1:0] freeze_count,
	input wire logic [15:0] blink_count
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence restart_s;
		freeze_count == 2'h3 ##0 $fell(pixel_clk_true);
	endsequence
	lat_powerup_a: assert property (latency_fixed || latency_cycles == 4'h6)
		else $error("latency moved without alignment");
	align_eight_a: assert property (restart_s |=> latency_fixed && latency_cycles == 4'h8)
		else $error("restart did not fix latency");
	phase_realign_a: assert property (restart_s |=> serial_phase == 3'h0)
		else $error("restart did not realign serializer phase");
	align_hold_a: assert property (latency_fixed |=> latency_fixed && latency_cycles == 4'h8)
		else $error("aligned latency lost");
	freeze_clear_a: assert property ($fell(pixel_clk_true) |=> freeze_count == 2'h0)
		else $error("freeze count kept over a clock fall");
	blink_step_a: assert property ($rose(load_strobe) |=> blink_count == $past(blink_count) + 16'h1)
		else $error("blink counter did not step");
endmodule
bind pixel_load_pipeline_sync sync_checker sync_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.pixel_clk_true(pixel_clk_true), .load_strobe(load_strobe), .latency_cycles(latency_cycles),
	.latency_fixed(latency_fixed), .serial_phase(serial_phase), .freeze_count(freeze_count),
	.blink_count(blink_count));
`default_nettype wire

// ### verilog/latency_line.sv
`default_nettype none
module latency_line #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// shift control
	input wire logic shift_en,
	input wire logic [3:0] latency,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	import pixel_sync_pkg::*;

	initial begin
		if (WIDTH < 1 || DEPTH < 1 || DEPTH > 15)
			$error("latency_line: unsupported WIDTH or DEPTH");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] taps;
		logic [WIDTH-1:0] out;
	} line_state_t;

	line_state_t state_reg;
	line_state_t state_next;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		if (shift_en) begin
			// sample taken latency ticks ago appears now
			if (latency >= 4'h1 && int'(latency) <= DEPTH) begin
				state_next.out = state_reg.taps[latency - 4'h1];
			end
			state_next.taps[0] = din;
			for (int i = 1; i < DEPTH; i++) begin
				state_next.taps[i] = state_reg.taps[i-1];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign dout = state_reg.out;
endmodule
`default_nettype wire

// ### verilog/pixel_load_pipeline_sync.sv
// Function
// - without alignment the pipeline latency is some fixed value from six to ten.
// - finishing the hold-and-restart sequence fixes latency at exactly eight cycles.
// - alignment leaves the blink counter untouched.
// - the frozen state may last any time without losing the alignment.
// - blink circuitry is initialised by reset, usable without alignment.
`default_nettype none
module pixel_load_pipeline_sync #(
	parameter int PIXEL_WIDTH = 8,
	parameter logic [3:0] POWERUP_LATENCY = pixel_sync_pkg::LATENCY_MIN
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// pixel clock pair and load strobe from the clock generator
	input wire logic pixel_clk_true,
	input wire logic pixel_clk_comp,
	input wire logic load_strobe,
	// configuration
	input wire logic mux_5to1,
	// pixel data
	input wire logic [PIXEL_WIDTH-1:0] pixel_in,
	output logic [PIXEL_WIDTH-1:0] pixel_out,
	// status
	output logic [2:0] serial_phase,
	output logic [3:0] latency_cycles,
	output logic latency_fixed,
	output logic [1:0] freeze_count,
	output logic [pixel_sync_pkg::BLINK_WIDTH-1:0] blink_count
);
	import pixel_sync_pkg::*;

	initial begin
		if (PIXEL_WIDTH < 1)
			$error("pixel_load_pipeline_sync: PIXEL_WIDTH must be positive");
		if (POWERUP_LATENCY < LATENCY_MIN || POWERUP_LATENCY > LATENCY_MAX)
			$error("pixel_load_pipeline_sync: POWERUP_LATENCY outside six to ten");
	end

	typedef struct packed {
		logic clk_true_d;
		logic load_d;
		logic [1:0] freeze_edges;
		logic armed;
		logic fixed;
		logic [3:0] latency;
		logic [2:0] phase;
		logic [BLINK_WIDTH-1:0] blink;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	logic clk_rise;
	logic clk_fall;
	logic load_rise;
	logic frozen_level;
	logic [2:0] ratio_last;

	////////////////////////////////////////////////////////////////////////
	// edge detection on the sampled clock pins
	assign clk_rise = pixel_clk_true && !state_reg.clk_true_d;
	assign clk_fall = !pixel_clk_true && state_reg.clk_true_d;
	assign load_rise = load_strobe && !state_reg.load_d;
	assign frozen_level = pixel_clk_true && !pixel_clk_comp;
	// serializer wraps at ratio minus one
	assign ratio_last = (mux_5to1 ? MUX_RATIO_5 : MUX_RATIO_4) - 3'h1;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		state_next.clk_true_d = pixel_clk_true;
		state_next.load_d = load_strobe;

		// a running clock leaves at most one load edge per high phase
		if (clk_fall) begin
			state_next.freeze_edges = FREEZE_COUNT_RESET;
		end else if (frozen_level && load_rise && state_reg.freeze_edges != FREEZE_EDGES) begin
			state_next.freeze_edges = state_reg.freeze_edges + 2'h1;
		end
		// arming survives an unlimited hold; only the restart consumes it
		if (frozen_level && load_rise && state_reg.freeze_edges == FREEZE_EDGES - 2'h1) begin
			state_next.armed = 1'b1;
		end

		// serializer phase follows pixel clock rising edges
		if (clk_rise) begin
			if (state_reg.phase >= ratio_last) begin
				state_next.phase = PHASE_RESET;
			end else begin
				state_next.phase = state_reg.phase + 3'h1;
			end
		end

		// restart after a qualified freeze: realign and fix the latency
		if (clk_fall && state_reg.armed) begin
			state_next.armed = 1'b0;
			state_next.phase = PHASE_RESET;
			state_next.latency = LATENCY_ALIGNED;
			state_next.fixed = 1'b1;
		end

		// blink timing runs from load strobe and only reset clears it
		if (load_rise) begin
			state_next.blink = state_reg.blink + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.clk_true_d <= 1'b0;
			state_reg.load_d <= 1'b0;
			state_reg.freeze_edges <= FREEZE_COUNT_RESET;
			state_reg.armed <= 1'b0;
			state_reg.fixed <= 1'b0;
			state_reg.latency <= POWERUP_LATENCY;
			state_reg.phase <= PHASE_RESET;
			state_reg.blink <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pixel pipeline advancing on each pixel clock rising edge
	latency_line #(
		.WIDTH(PIXEL_WIDTH),
		.DEPTH(LATENCY_DEPTH)
	) u_line (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.shift_en(clk_rise),
		.latency(state_reg.latency),
		.din(pixel_in),
		.dout(pixel_out)
	);

	assign serial_phase = state_reg.phase;
	assign latency_cycles = state_reg.latency;
	assign latency_fixed = state_reg.fixed;
	assign freeze_count = state_reg.freeze_edges;
	assign blink_count = state_reg.blink;
endmodule
`default_nettype wire
